// ### hw/quad_serial_flash_interface.sv
// Purpose: serial flash controller, single/dual/quad half-duplex link
// Assumes: command and memory ports on clock_i; io_i from the pins
// Notes:   serial clock made by a divider; memory reads fetch a word
// Operation
// - memory-region reads of any width return the addressed word.
// - the link is half duplex on one, two or four data lines.
// - frames open with the controller sending the opcode, except frames that leave the opcode out.
// - in write frames the controller drives every field.
// - in read frames the controller releases the lines for data.
// - commands come from software or from memory-region reads.
// - fields go out as opcode, address, intermediate, data.
// - address, intermediate and data fields may each be empty.
// - an implied-opcode read mode leaves out the opcode.
// - the data field is input or output as the command says.
`default_nettype none
module quad_serial_flash_interface #(
	parameter int FIFO_DEPTH = qsf_pkg::FIFO_DEPTH,
	parameter int MEM_AW     = qsf_pkg::MEM_AW
) (
	input  wire logic              clock_i,
	input  wire logic              arst_n_i,
	input  wire logic              ce_i,
	input  wire logic              cmd_valid_i,
	input  wire logic [7:0]        cmd_opcode_i,
	input  wire logic [31:0]       cmd_addr_i,
	input  wire logic [2:0]        cmd_addr_bytes_i,
	input  wire logic [7:0]        cmd_inter_i,
	input  wire logic [2:0]        cmd_inter_bytes_i,
	input  wire logic [15:0]       cmd_data_len_i,
	input  wire logic              cmd_data_out_i,
	input  wire logic [1:0]        cmd_lanes_i,
	input  wire logic              cmd_no_opcode_i,
	output logic                   cmd_ready_o,
	input  wire logic              wr_valid_i,
	input  wire logic [7:0]        wr_data_i,
	output logic                   wr_ready_o,
	output logic                   rd_valid_o,
	output logic [7:0]             rd_data_o,
	input  wire logic              rd_ready_i,
	input  wire logic              mem_req_i,
	input  wire logic [MEM_AW-1:0] mem_addr_i,
	output logic                   mem_ready_o,
	output logic [31:0]            mem_rdata_o,
	input  wire logic [7:0]        mm_opcode_i,
	input  wire logic [2:0]        mm_addr_bytes_i,
	input  wire logic [7:0]        mm_inter_i,
	input  wire logic [2:0]        mm_inter_bytes_i,
	input  wire logic [1:0]        mm_lanes_i,
	input  wire logic              mm_implied_i,
	output logic                   sck_o,
	output logic                   cs_n_o,
	output logic [3:0]             io_o,
	output logic [3:0]             io_oe_n_o,
	input  wire logic [3:0]        io_i
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [3:0] lane_mask(input logic [1:0] l);
		lane_mask = (l == qsf_pkg::LANES_4) ? 4'hF :
			(l == qsf_pkg::LANES_2) ? 4'h3 : 4'h1;
	endfunction

	function automatic logic [3:0] lane_bits(input logic [1:0] l);
		lane_bits = (l == qsf_pkg::LANES_4) ? 4'h4 :
			(l == qsf_pkg::LANES_2) ? 4'h2 : 4'h1;
	endfunction

	function automatic logic [3:0] top_bits(input logic [7:0] b,
		input logic [1:0] l);
		top_bits = (l == qsf_pkg::LANES_4) ? b[7:4] :
			(l == qsf_pkg::LANES_2) ? {2'h0, b[7:6]} : {3'h0, b[7]};
	endfunction

	// skip empty fields
	// next non-empty field after s, or the frame end
	function automatic qsf_pkg::state_t after(input qsf_pkg::state_t s,
		input logic [2:0] ab, input logic [2:0] ib, input logic [15:0] dl);
		logic early;
		early = (s == qsf_pkg::S_IDLE) || (s == qsf_pkg::S_OPC);
		if (early && ab != 3'h0) begin
			after = qsf_pkg::S_ADDR;
		end else if ((early || s == qsf_pkg::S_ADDR) && ib != 3'h0) begin
			after = qsf_pkg::S_INTER;
		end else if (s != qsf_pkg::S_DATA && dl != 16'h0) begin
			after = qsf_pkg::S_DATA;
		end else begin
			after = qsf_pkg::S_FIN;
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	qsf_pkg::state_t st_r;
	logic [3:0]  div_r, bit_r, io_r, oe_n_r, io_s1_r, io_s2_r;
	logic [7:0]  sh_r, opc_r, inter_r, rd_data_r;
	logic [15:0] cnt_r, dlen_r;
	logic [31:0] addr_r, mdata_r;
	logic [2:0]  ab_r, ib_r;
	logic [1:0]  lanes_r;
	logic        sck_r, cs_n_r, out_r, noop_r, mem_r, armed_r;
	logic        rd_valid_r, mem_ready_r, cmd_ready_r;
	logic        f_valid;
	logic [7:0]  f_data;

	// ****************************************************************
	// decode
	// ****************************************************************
	wire take_cmd = (st_r == qsf_pkg::S_IDLE) & cmd_valid_i & cmd_ready_r;
	// software commands win; a finished fetch blocks one cycle of re-take
	wire take_mem = (st_r == qsf_pkg::S_IDLE) & mem_req_i & ~mem_ready_r
		& ~(cmd_valid_i & cmd_ready_r);
	wire take = take_cmd | take_mem;
	wire [2:0] sel_ab = take_mem ? mm_addr_bytes_i : cmd_addr_bytes_i;
	wire [31:0] sel_addr = take_mem ?
		{{(32-MEM_AW){1'b0}}, mem_addr_i[MEM_AW-1:2], 2'h0} : cmd_addr_i;
	wire [2:0] pad_bytes = 3'h4 - sel_ab;
	wire active = (st_r == qsf_pkg::S_OPC) | (st_r == qsf_pkg::S_ADDR)
		| (st_r == qsf_pkg::S_INTER) | (st_r == qsf_pkg::S_DATA);
	wire tick = (div_r == 4'h0);
	wire [3:0] w = lane_bits(lanes_r);
	wire [3:0] bit_sum = bit_r + w;
	wire in_field = (st_r == qsf_pkg::S_DATA) & ~out_r;
	wire rise = active & tick & ~sck_r;
	wire fall_try = active & tick & sck_r;
	wire byte_end = fall_try & (bit_sum == qsf_pkg::BYTE_BITS);
	wire is_start = (st_r == qsf_pkg::S_START);
	wire new_field = is_start | (byte_end & (cnt_r == 16'h1));
	wire qsf_pkg::state_t start_st = noop_r ?
		after(qsf_pkg::S_IDLE, ab_r, ib_r, dlen_r) : qsf_pkg::S_OPC;
	wire qsf_pkg::state_t ld_st = is_start ? start_st :
		new_field ? after(st_r, ab_r, ib_r, dlen_r) : st_r;
	wire ld = is_start | byte_end;
	wire need_wr = ld & (ld_st == qsf_pkg::S_DATA) & out_r;
	wire in_done = byte_end & in_field;
	// clock is held high while write data is missing or read data unread
	wire stall = (need_wr & ~f_valid) | (in_done & ~mem_r & rd_valid_r);
	wire go = ~stall;
	wire fall = fall_try & go;
	wire ld_go = ld & go;
	wire rel = ((ld_st == qsf_pkg::S_DATA) & ~out_r)
		| (ld_st == qsf_pkg::S_FIN);
	wire [15:0] cnt_ld = ~new_field ? cnt_r - 16'h1 :
		(ld_st == qsf_pkg::S_OPC) ? 16'h1 :
		(ld_st == qsf_pkg::S_ADDR) ? {13'h0, ab_r} :
		(ld_st == qsf_pkg::S_INTER) ? {13'h0, ib_r} : dlen_r;
	wire [7:0] ld_byte = (ld_st == qsf_pkg::S_OPC) ? opc_r :
		(ld_st == qsf_pkg::S_ADDR) ? addr_r[31:24] :
		(ld_st == qsf_pkg::S_INTER) ? inter_r :
		((ld_st == qsf_pkg::S_DATA) & out_r) ? f_data : 8'h00;
	wire [7:0] sh_out = sh_r << w;
	wire [7:0] sh_in = (lanes_r == qsf_pkg::LANES_4) ? {sh_r[3:0], io_s2_r} :
		(lanes_r == qsf_pkg::LANES_2) ? {sh_r[5:0], io_s2_r[1:0]} :
		{sh_r[6:0], io_s2_r[1]};

	assign cmd_ready_o = cmd_ready_r;
	assign rd_valid_o  = rd_valid_r;
	assign rd_data_o   = rd_data_r;
	assign mem_ready_o = mem_ready_r;
	assign mem_rdata_o = mdata_r;
	assign sck_o       = sck_r;
	assign cs_n_o      = cs_n_r;
	assign io_o        = io_r;
	assign io_oe_n_o   = oe_n_r;

	// ****************************************************************
	// write buffer
	// ****************************************************************
	// write data
	qsf_fifo #(.WIDTH(qsf_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.arst_n_i    (arst_n_i),
		.ce_i        (ce_i),
		.in_valid_i  (wr_valid_i),
		.in_data_i   (wr_data_i),
		.in_ready_o  (wr_ready_o),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (need_wr & go)
	);

	// ****************************************************************
	// frame setup
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{opc_r, inter_r, ab_r, ib_r, lanes_r} <= '0;
			{dlen_r, out_r, noop_r, mem_r} <= '0;
		end else if (ce_i && take) begin
			opc_r   <= take_mem ? mm_opcode_i : cmd_opcode_i;
			inter_r <= take_mem ? mm_inter_i : cmd_inter_i;
			ab_r    <= sel_ab;
			ib_r    <= take_mem ? mm_inter_bytes_i : cmd_inter_bytes_i;
			lanes_r <= take_mem ? mm_lanes_i : cmd_lanes_i;
			dlen_r  <= take_mem ? qsf_pkg::MEM_FETCH_LEN : cmd_data_len_i;
			out_r   <= take_cmd & cmd_data_out_i;
			noop_r  <= take_mem ? (mm_implied_i & armed_r) : cmd_no_opcode_i;
			mem_r   <= take_mem;
		end
	end

	// ****************************************************************
	// sequencer and serial clock
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r  <= qsf_pkg::S_IDLE;
			div_r <= qsf_pkg::DIV_RELOAD;
			sck_r <= 1'b0;
			bit_r <= 4'h0;
			cnt_r <= 16'h0;
		end else if (ce_i) begin
			if (take) begin
				st_r <= qsf_pkg::S_START;
			end else if (ld_go) begin
				st_r <= ld_st;
			end else if (st_r == qsf_pkg::S_FIN && tick) begin
				st_r <= qsf_pkg::S_IDLE;
			end
			if (is_start || (tick && go)) begin
				div_r <= qsf_pkg::DIV_RELOAD;
			end else if (!tick) begin
				div_r <= div_r - 4'h1;
			end
			if (rise) begin
				sck_r <= 1'b1;
			end else if (fall) begin
				sck_r <= 1'b0;
			end
			if (is_start || fall) begin
				bit_r <= (is_start || byte_end) ? 4'h0 : bit_sum;
			end
			if (ld_go) begin
				cnt_r <= cnt_ld;
			end
		end
	end

	// ****************************************************************
	// shifter and pins
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sh_r    <= 8'h00;
			addr_r  <= 32'h0;
			io_r    <= 4'h0;
			oe_n_r  <= qsf_pkg::OE_OFF;
			cs_n_r  <= 1'b1;
			io_s1_r <= 4'h0;
			io_s2_r <= 4'h0;
		end else if (ce_i) begin
			io_s1_r <= io_i;
			io_s2_r <= io_s1_r;
			if (take) begin
				addr_r <= sel_addr << {pad_bytes, 3'h0};
			end else if (ld_go && ld_st == qsf_pkg::S_ADDR) begin
				addr_r <= addr_r << 8;
			end
			if (ld_go) begin
				sh_r <= ld_byte;
				io_r <= top_bits(ld_byte, lanes_r);
				oe_n_r <= rel ? qsf_pkg::OE_OFF : ~lane_mask(lanes_r);
				cs_n_r <= (ld_st == qsf_pkg::S_FIN);
			end else if (rise && in_field) begin
				sh_r <= sh_in;
			end else if (fall && !in_field) begin
				sh_r <= sh_out;
				io_r <= top_bits(sh_out, lanes_r);
			end
		end
	end

	// ****************************************************************
	// returned data
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{rd_valid_r, rd_data_r, mdata_r, mem_ready_r, armed_r} <= '0;
			cmd_ready_r <= 1'b1;
		end else if (ce_i) begin
			if (in_done && go && !mem_r) begin
				rd_valid_r <= 1'b1;
				rd_data_r  <= sh_r;
			end else if (rd_ready_i) begin
				rd_valid_r <= 1'b0;
			end
			if (in_done && mem_r) begin
				mdata_r <= {sh_r, mdata_r[31:8]};
			end
			mem_ready_r <= (st_r == qsf_pkg::S_FIN) & tick & mem_r;
			if (take) begin
				cmd_ready_r <= 1'b0;
			end else if (st_r == qsf_pkg::S_FIN && tick) begin
				cmd_ready_r <= 1'b1;
			end
			if (take_cmd) begin
				armed_r <= 1'b0;
			end else if (st_r == qsf_pkg::S_FIN && tick && mem_r) begin
				armed_r <= mm_implied_i;
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_cs_frame;
		@(posedge clock_i) disable iff (!arst_n_i)
		active |-> !cs_n_o;
	endproperty
	a_cs_frame: assert property (p_cs_frame)
		else $error("cs high in frame");

	property p_width;
		@(posedge clock_i) disable iff (!arst_n_i)
		active |-> (io_oe_n_o == qsf_pkg::OE_OFF
			|| io_oe_n_o == ~lane_mask(lanes_r));
	endproperty
	a_width: assert property (p_width)
		else $error("bad lane enables");

	property p_open;
		@(posedge clock_i) disable iff (!arst_n_i)
		$fell(cs_n_o) |-> (st_r == qsf_pkg::S_OPC || noop_r);
	endproperty
	a_open: assert property (p_open)
		else $error("frame without opcode");

	property p_wr_drive;
		@(posedge clock_i) disable iff (!arst_n_i)
		(st_r == qsf_pkg::S_DATA && out_r) |-> io_oe_n_o != qsf_pkg::OE_OFF;
	endproperty
	a_wr_drive: assert property (p_wr_drive)
		else $error("write released");

	property p_release;
		@(posedge clock_i) disable iff (!arst_n_i)
		in_field |-> io_oe_n_o == qsf_pkg::OE_OFF;
	endproperty
	a_release: assert property (p_release)
		else $error("read data driven");

	property p_order;
		@(posedge clock_i) disable iff (!arst_n_i)
		(st_r == qsf_pkg::S_ADDR && $past(st_r) != qsf_pkg::S_ADDR)
			|-> $past(st_r) inside {qsf_pkg::S_OPC, qsf_pkg::S_START};
	endproperty
	a_order: assert property (p_order)
		else $error("address out of order");

	property p_skip;
		@(posedge clock_i) disable iff (!arst_n_i)
		(st_r == qsf_pkg::S_INTER) |-> ib_r != 3'h0;
	endproperty
	a_skip: assert property (p_skip)
		else $error("empty field sent");

	property p_implied;
		@(posedge clock_i) disable iff (!arst_n_i)
		(is_start && mem_r) |-> noop_r == $past(armed_r & mm_implied_i);
	endproperty
	a_implied: assert property (p_implied)
		else $error("implied mode wrong");

	property p_word;
		@(posedge clock_i) disable iff (!arst_n_i)
		(is_start && mem_r) |-> (dlen_r == qsf_pkg::MEM_FETCH_LEN && !out_r);
	endproperty
	a_word: assert property (p_word)
		else $error("fetch not a word read");
endmodule // quad_serial_flash_interface
`default_nettype wire

// ### hw/qsf_pkg.sv
// Purpose: shared constants and types of the quad serial flash interface
// Assumes: 100 MHz system clock
// Notes:   link clock divider reload is set here from the system clock period
`default_nettype none
package qsf_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// least half period of the serial clock
	localparam int SCK_HALF_NS = 40;
	localparam int SCK_HALF_CYC =
		(SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DIV_RELOAD = 4'(SCK_HALF_CYC - 1);
	localparam int FIFO_DEPTH = 16;
	localparam int BYTE_W = 8;
	localparam int MEM_AW = 24;
	localparam logic [15:0] MEM_FETCH_LEN = 16'h0004;
	localparam logic [1:0] LANES_1 = 2'h0;
	localparam logic [1:0] LANES_2 = 2'h1;
	localparam logic [1:0] LANES_4 = 2'h2;
	localparam logic [3:0] OE_OFF = 4'hF;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_START = 7'h02,
		S_OPC   = 7'h04,
		S_ADDR  = 7'h08,
		S_INTER = 7'h10,
		S_DATA  = 7'h20,
		S_FIN   = 7'h40
	} state_t;
endpackage
`default_nettype wire

// ### hw/qsf_fifo.sv
// Purpose: write data buffer between the user and the serial engine
// Assumes: both sides on clock_i
// Notes:   in_ready_o comes straight from a flop
`default_nettype none
module qsf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             nfull_r;
	wire              push = ce_i & in_valid_i & nfull_r;
	wire              pop = ce_i & out_ready_i & out_valid_o;

	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];
	assign in_ready_o  = nfull_r;
	assign cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_r    <= '0;
			rp_r    <= '0;
			cnt_r   <= '0;
			nfull_r <= 1'b1;
		end else if (ce_i) begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r   <= cnt_nxt;
			nfull_r <= (cnt_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule // qsf_fifo
`default_nettype wire

// ### bench/flash_model.sv
// Purpose: behavioural serial flash on the far side of the link
// Assumes: bench preloads read bytes into q and sets lanes_i per frame
// Notes:   released lines toggle each cycle so stale bits never pass
`default_nettype none
module flash_model (
	input  wire logic       clock_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic [3:0] ctl_io_i,
	input  wire logic [3:0] ctl_oe_n_i,
	input  wire logic [1:0] lanes_i,
	output logic      [3:0] io_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	logic [7:0] seen[$];
	logic [7:0] sh_r = 8'h00;
	logic [3:0] drv_r = 4'h0;
	logic [3:0] flt_r = 4'h5;
	logic [3:0] use_w;
	logic       sck_p = 1'b0;
	logic       rel_p = 1'b0;
	logic       rel;
	int         left_r = 0;
	int         bw;
	assign rel = !cs_n_i && (ctl_oe_n_i == 4'hF);
	assign bw = (lanes_i == 2'h2) ? 4 : (lanes_i == 2'h1) ? 2 : 1;
	assign use_w = (bw == 4) ? 4'hF : (bw == 2) ? 4'h3 : 4'h2;
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			io_o[k] = !ctl_oe_n_i[k] ? ctl_io_i[k] :
				(rel && use_w[k]) ? drv_r[k] : flt_r[k];
		end
	end
	// flash samples on the rising serial clock
	always @(posedge sck_i) begin
		if (!cs_n_i)
			seen.push_back({ctl_oe_n_i, io_o});
	end
	always @(posedge clock_i) begin : shift
		logic [7:0] b;
		flt_r <= ~flt_r;
		sck_p <= sck_i;
		rel_p <= rel;
		b = sh_r;
		if (cs_n_i) begin
			left_r <= 0;
		end else if (rel && (!rel_p || (sck_p && !sck_i))) begin
			if (left_r == 0)
				b = (q.size() != 0) ? q.pop_front() : 8'hA5;
			if (bw == 4)
				drv_r <= b[7:4];
			else if (bw == 2)
				drv_r <= {2'h0, b[7:6]};
			else
				drv_r <= {2'h0, b[7], 1'b0};
			sh_r <= b << bw;
			left_r <= ((left_r == 0) ? 8 : left_r) - bw;
		end
	end
endmodule // flash_model
`default_nettype wire

// ### bench/quad_serial_flash_interface_bench.sv
// Purpose: self-checking bench of the serial flash controller
// Assumes: every field of a frame runs at the command's line width
// Notes:   frames are rebuilt from byte queues, never from dut outputs
`default_nettype none
module quad_serial_flash_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0, arst_n_i = 1'b0, cmd_valid_i = 1'b0;
	logic        cmd_data_out_i = 1'b0, wr_valid_i = 1'b0, rd_ready_i = 1'b0;
	logic        mem_req_i = 1'b0, mm_implied_i = 1'b1, implied_ok = 1'b0;
	logic        cmd_no_opcode_i = 1'b0;
	logic        cmd_ready_o, wr_ready_o, rd_valid_o, mem_ready_o, sck_o;
	logic        cs_n_o;
	logic [7:0]  cmd_opcode_i = 8'h00, cmd_inter_i = 8'h00;
	logic [7:0]  wr_data_i = 8'h00, rd_data_o;
	logic [7:0]  mm_opcode_i = 8'h3B, mm_inter_i = 8'hA0;
	logic [31:0] cmd_addr_i = 32'h0, mem_rdata_o;
	logic [2:0]  cmd_addr_bytes_i = 3'h0, cmd_inter_bytes_i = 3'h0;
	logic [2:0]  mm_addr_bytes_i = 3'h3, mm_inter_bytes_i = 3'h1;
	logic [15:0] cmd_data_len_i = 16'h0;
	logic [1:0]  cmd_lanes_i = 2'h0, mm_lanes_i = 2'h0, fl_lanes = 2'h0;
	logic [23:0] mem_addr_i = 24'h0;
	logic [3:0]  io_o, io_oe_n_o, io_lvl;
	logic [7:0]  exp_q[$], got_q[$];
	int          n_fail = 0, checked = 0;

	quad_serial_flash_interface uut (.clock_i, .arst_n_i, .ce_i(1'b1),
		.cmd_valid_i, .cmd_opcode_i, .cmd_addr_i, .cmd_addr_bytes_i,
		.cmd_inter_i, .cmd_inter_bytes_i, .cmd_data_len_i, .cmd_data_out_i,
		.cmd_lanes_i, .cmd_no_opcode_i, .cmd_ready_o, .wr_valid_i,
		.wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_ready_i,
		.mem_req_i, .mem_addr_i, .mem_ready_o, .mem_rdata_o, .mm_opcode_i,
		.mm_addr_bytes_i, .mm_inter_i, .mm_inter_bytes_i, .mm_lanes_i,
		.mm_implied_i, .sck_o, .cs_n_o, .io_o, .io_oe_n_o, .io_i(io_lvl));
	flash_model fl (.clock_i, .sck_i(sck_o), .cs_n_i(cs_n_o), .ctl_io_i(io_o),
		.ctl_oe_n_i(io_oe_n_o), .lanes_i(fl_lanes), .io_o(io_lvl));

	initial begin
		forever #5 clock_i = ~clock_i;
	end
	// random consumer stalls exercise the read back-pressure
	always @(posedge clock_i) begin
		rd_ready_i <= 1'($urandom_range(0, 1));
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
			got_q.push_back(rd_data_o);
	end

	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		checked++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_on(input int sel);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (((sel == 0) ? cmd_ready_o : (sel == 1) ? mem_ready_o :
			wr_ready_o) !== 1'b1 && n < 40000);
		if (n >= 40000) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	// decode each slot back into bytes; oe shows who drove it
	task automatic chk_frame(input int w, input int n_out);
		int idx, k, s;
		logic [7:0] b, v;
		logic [3:0] e;
		idx = 0;
		chk(fl.seen.size(), exp_q.size() * 8 / w);
		for (k = 0; k < exp_q.size(); k++) begin
			b = 8'h00;
			for (s = 0; s < 8 / w; s++) begin
				v = fl.seen[idx];
				idx++;
				e = (w == 4) ? 4'h0 : (w == 2) ? 4'hC : 4'hE;
				chk(v[7:4], (k >= n_out) ? 4'hF : e);
				if (w == 4)
					b = {b[3:0], v[3:0]};
				else if (w == 2)
					b = {b[5:0], v[1:0]};
				else
					b = {b[6:0], (k < n_out) ? v[0] : v[1]};
			end
			chk(b, exp_q[k]);
		end
	endtask
	task automatic run_cmd(input logic [7:0] op, input logic [31:0] a,
		input logic [2:0] ab, input logic [2:0] ib, input logic [15:0] dl,
		input logic dout, input logic [1:0] ln);
		fl.seen.delete();
		fl_lanes <= ln;
		cmd_opcode_i <= op;
		cmd_addr_i <= a;
		cmd_addr_bytes_i <= ab;
		cmd_inter_bytes_i <= ib;
		cmd_data_len_i <= dl;
		cmd_data_out_i <= dout;
		cmd_lanes_i <= ln;
		cmd_valid_i <= 1'b1;
		wait_on(0);
		cmd_valid_i <= 1'b0;
		@(posedge clock_i);
		wait_on(0);
		chk(cs_n_o, 1'b1);
		implied_ok = 1'b0;
	endtask
	task automatic mem_rd(input logic [23:0] a, input int w);
		logic [7:0] d[4];
		int i, n;
		exp_q.delete();
		fl.seen.delete();
		mem_addr_i <= a;
		a[1:0] = 2'b00;
		if (!implied_ok)
			exp_q.push_back(mm_opcode_i);
		for (i = 2; i >= 0; i--)
			exp_q.push_back(a[8*i +: 8]);
		exp_q.push_back(mm_inter_i);
		n = exp_q.size();
		for (i = 0; i < 4; i++) begin
			d[i] = 8'($urandom);
			exp_q.push_back(d[i]);
			fl.q.push_back(d[i]);
		end
		mm_lanes_i <= (w == 4) ? 2'h2 : 2'(w - 1);
		fl_lanes <= (w == 4) ? 2'h2 : 2'(w - 1);
		mem_req_i <= 1'b1;
		wait_on(1);
		mem_req_i <= 1'b0;
		chk(mem_rdata_o, {d[3], d[2], d[1], d[0]});
		repeat (8) @(posedge clock_i);
		chk(cs_n_o, 1'b1);
		chk_frame(w, n);
		implied_ok = mm_implied_i;
		$display("test memory read at %h done", a);
	endtask

	initial begin : main
		int w, i;
		logic [7:0] b;
		logic [31:0] a;
		void'($urandom(95));
		repeat (8) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		chk({cmd_ready_o, cs_n_o, sck_o, io_oe_n_o, wr_ready_o, rd_valid_o,
			mem_ready_o}, {3'b110, 4'hF, 3'b100});
		$display("test reset done");
		mem_rd(24'h000103, 1);
		mem_rd(24'h00ABC6, 2);
		for (w = 1; w <= 4; w = w * 2) begin
			exp_q.delete();
			a = $urandom;
			exp_q.push_back(8'h32);
			for (i = 2; i >= 0; i--)
				exp_q.push_back(a[8*i +: 8]);
			for (i = 0; i < w; i++)
				exp_q.push_back(8'hC3);
			for (i = 0; i < 16; i++) begin
				b = 8'($urandom);
				exp_q.push_back(b);
				wr_data_i <= b;
				wr_valid_i <= 1'b1;
				wait_on(2);
			end
			@(posedge clock_i);
			chk(wr_ready_o, 1'b0);
			wr_valid_i <= 1'b0;
			cmd_inter_i <= 8'hC3;
			run_cmd(8'h32, a, 3'h3, 3'(w), 16'h0010, 1'b1, 2'(w / 2));
			chk_frame(w, exp_q.size());
			$display("test write at width %0d done", w);
			exp_q.delete();
			got_q.delete();
			// software read without opcode at quad width
			cmd_no_opcode_i <= (w == 4);
			if (w != 4)
				exp_q.push_back(8'h6B);
			exp_q.push_back(8'h5A);
			for (i = 0; i < 3; i++) begin
				b = 8'($urandom);
				exp_q.push_back(b);
				fl.q.push_back(b);
			end
			cmd_inter_i <= 8'h5A;
			run_cmd(8'h6B, 32'h0, 3'h0, 3'h1, 16'h0003, 1'b0, 2'(w / 2));
			chk_frame(w, exp_q.size() - 3);
			for (i = 0; i < 60 && got_q.size() < 3; i++)
				@(posedge clock_i);
			chk(got_q.size(), 3);
			for (i = 0; i < 3; i++)
				chk(got_q[i], exp_q[exp_q.size() - 3 + i]);
			$display("test read at width %0d done", w);
		end
		mem_rd(24'h123458, 4);
		tally_and_finish();
	end
endmodule // quad_serial_flash_interface_bench
`default_nettype wire
